/* File: common/spp_consts.vh */
// Constants for the sink attach and power-path controller: offsets, fields, resets, timing.
// Assumes a 200 MHz system clock and register access over the two-wire serial pins.
`ifndef SPP_CONSTS_VH
`define SPP_CONSTS_VH

// Register offsets
`define SPP_REG_CONN 8'h0E
`define SPP_REG_OPSTATE 8'h11
`define SPP_REG_CCSUP 8'h18
`define SPP_REG_ILIM 8'h1E
`define SPP_REG_MONCFG 8'h20
`define SPP_REG_VTARGET 8'h21
`define SPP_REG_VSHIFT 8'h22
`define SPP_REG_PWRACC 8'h24
`define SPP_REG_DISTIME 8'h25
`define SPP_REG_DISCTL 8'h26
`define SPP_REG_ROLE 8'h28
`define SPP_REG_MONDIS 8'h2E

// Reset values
`define SPP_RST_STARTUP 1'h0
`define SPP_RST_VTARGET 6'h32
`define SPP_RST_SHIFT 4'hA
`define SPP_RST_PWRACC 1'h1
`define SPP_RST_DIS0V 4'hA
`define SPP_RST_DISTRANS 4'hA
`define SPP_RST_DISEN 1'h1
`define SPP_RST_RANGEOFF 1'h0
`define SPP_RST_ROLE 3'h1

// Connection report codes
`define SPP_CONN_NONE 8'h00
`define SPP_CONN_SINK 8'h41
`define SPP_CONN_DEBUG 8'h61
`define SPP_CONN_AUDIO 8'h81

// Line termination codes as sensed
`define SPP_TERM_OPEN 2'h0
`define SPP_TERM_RA 2'h1
`define SPP_TERM_RD 2'h2
`define SPP_TERM_RP 2'h3

// Timing
`define SPP_CLK_PERIOD_NS 5
`define SPP_TOGGLE_TIME_NS 50000
`define SPP_TOGGLE_CYCLES (`SPP_TOGGLE_TIME_NS / `SPP_CLK_PERIOD_NS)

// Serial slave address
`define SPP_DEV_ADDR 7'h28

`endif

/* File: hw/spp_sink_attach_ctrl.v */
// Sink-role attach detection, power-path gating and configuration registers.
// Assumes serial pins and line terminations are already synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "spp_consts.vh"

module spp_sink_attach_ctrl #(
  parameter TOGGLE_CYCLES = `SPP_TOGGLE_CYCLES,
  parameter [6:0] DEV_ADDR = `SPP_DEV_ADDR,
  parameter [2:0] NVM_ROLE_DEFAULT = `SPP_RST_ROLE
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Serial register access
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOeN,
  // Nonvolatile power-role value
  input wire [2:0] nvmPowerRole,
  // Line terminations and advertised levels
  input wire [1:0] cc1Term,
  input wire [1:0] cc2Term,
  input wire [1:0] cc1RpLevel,
  input wire [1:0] cc2RpLevel,
  // Bus voltage sense code
  input wire [5:0] busVoltageSenseIn,
  // Sink power path and orientation pins
  output wire sinkPathEnableN,
  output wire sinkPathOeN,
  output wire orientOut,
  output wire orientOeN,
  // Configuration outputs
  output wire startupLowPower,
  output wire cableSupplyOn,
  output wire dischargePathOn,
  output wire [3:0] dischargeToZeroTime,
  output wire [3:0] dischargeTransitionTime,
  output wire poweredAccessoryDetectOn
);

  localparam [2:0] I_IDLE = 3'h0, I_ADDR = 3'h1, I_ACK = 3'h2, I_WR = 3'h3, I_RD = 3'h4;
  localparam [2:0] I_MACK = 3'h5;
  localparam [2:0] S_UNSNK = 3'h0, S_UNACC = 3'h1, S_ATT = 3'h2, S_DBG = 3'h3, S_AUDIO = 3'h4;
  // Serial slave state
  reg sclPrev_ff, sdaPrev_ff, rdMode_ff, firstByte_ff, drive_ff, wrStb_ff;
  reg [2:0] iState_ff;
  reg [3:0] bitCnt_ff;
  reg [7:0] shift_ff, tx_ff, ptr_ff, wrAddr_ff, wrData_ff;
  reg [7:0] rdData;
  // Configuration fields
  reg startup_ff, pwrAcc_ff, disEn_ff, nvmPending_ff, rangeOff_ff;
  reg [7:0] ccSup_ff, ilim_ff, monCfg_ff;
  reg [5:0] vTarget_ff;
  reg [3:0] shiftHigh_ff, shiftLow_ff, dis0v_ff, disTrans_ff;
  reg [2:0] role_ff;
  // Attach state
  reg [2:0] aState_ff, nxt_aState;
  reg orientLow_ff, nxt_orientLow, pathOn_ff, toggleTick_ff;
  reg [31:0] toggleCnt_ff;
  reg [7:0] connCode;
  wire sclRise = sclIn & ~sclPrev_ff;
  wire sclFall = ~sclIn & sclPrev_ff;
  wire startCond = sclIn & sclPrev_ff & sdaPrev_ff & ~sdaIn;
  wire stopCond = sclIn & sclPrev_ff & ~sdaPrev_ff & sdaIn;
  wire rp1 = (cc1Term == `SPP_TERM_RP);
  wire rp2 = (cc2Term == `SPP_TERM_RP);
  wire ra1 = (cc1Term == `SPP_TERM_RA);
  wire ra2 = (cc2Term == `SPP_TERM_RA);
  wire unattached = (aState_ff == S_UNSNK) || (aState_ff == S_UNACC);
  wire detachNow = ~unattached && (nxt_aState == S_UNSNK);
  // Window is target minus low shift up to target plus high shift, in sense units
  wire [6:0] senseUp = {1'b0, busVoltageSenseIn} + {3'h0, shiftLow_ff};
  wire [6:0] targetUp = {1'b0, vTarget_ff} + {3'h0, shiftHigh_ff};
  wire inWindow = (senseUp >= {1'b0, vTarget_ff}) && ({1'b0, busVoltageSenseIn} <= targetUp);
  wire inRange = rangeOff_ff | inWindow;

  // Serial slave: pointer byte first, then auto-incremented data
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
      iState_ff <= I_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rdMode_ff <= 1'b0;
      firstByte_ff <= 1'b0;
      drive_ff <= 1'b0;
      wrStb_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      wrData_ff <= 8'h00;
    end else begin
      sclPrev_ff <= sclIn;
      sdaPrev_ff <= sdaIn;
      wrStb_ff <= 1'b0;
      if (startCond) begin
        iState_ff <= I_ADDR;
        bitCnt_ff <= 4'h0;
        drive_ff <= 1'b0;
      end else if (stopCond) begin
        iState_ff <= I_IDLE;
        drive_ff <= 1'b0;
      end else begin
        case (iState_ff)
          I_ADDR, I_WR: begin
            if (sclRise && bitCnt_ff != 4'h8) begin
              shift_ff <= {shift_ff[6:0], sdaIn};
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall && bitCnt_ff == 4'h8) begin
              bitCnt_ff <= 4'h0;
              if (iState_ff == I_ADDR) begin
                if (shift_ff[7:1] == DEV_ADDR) begin
                  drive_ff <= 1'b1;
                  rdMode_ff <= shift_ff[0];
                  firstByte_ff <= ~shift_ff[0];
                  iState_ff <= I_ACK;
                end else begin
                  iState_ff <= I_IDLE;
                end
              end else begin
                drive_ff <= 1'b1;
                iState_ff <= I_ACK;
                firstByte_ff <= 1'b0;
                if (firstByte_ff) begin
                  ptr_ff <= shift_ff;
                end else begin
                  wrStb_ff <= 1'b1;
                  wrAddr_ff <= ptr_ff;
                  wrData_ff <= shift_ff;
                  ptr_ff <= ptr_ff + 8'h01;
                end
              end
            end
          end
          I_ACK: begin
            if (sclFall) begin
              if (rdMode_ff) begin
                tx_ff <= rdData;
                drive_ff <= ~rdData[7];
                ptr_ff <= ptr_ff + 8'h01;
                bitCnt_ff <= 4'h1;
                iState_ff <= I_RD;
              end else begin
                drive_ff <= 1'b0;
                bitCnt_ff <= 4'h0;
                iState_ff <= I_WR;
              end
            end
          end
          I_RD: begin
            if (sclFall) begin
              if (bitCnt_ff == 4'h8) begin
                drive_ff <= 1'b0;
                iState_ff <= I_MACK;
              end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                drive_ff <= ~tx_ff[6];
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end
            end
          end
          I_MACK: begin
            // A not-acknowledge from the master ends the read burst
            if (sclRise) begin
              iState_ff <= sdaIn ? I_IDLE : I_ACK;
            end
          end
          default: begin
            drive_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    case (ptr_ff)
      `SPP_REG_CONN: rdData = connCode;
      `SPP_REG_OPSTATE: rdData = {5'h00, aState_ff};
      `SPP_REG_CCSUP: rdData = ccSup_ff;
      `SPP_REG_ILIM: rdData = ilim_ff;
      `SPP_REG_MONCFG: rdData = monCfg_ff;
      `SPP_REG_VTARGET: rdData = {2'h0, vTarget_ff};
      `SPP_REG_VSHIFT: rdData = {shiftHigh_ff, shiftLow_ff};
      `SPP_REG_PWRACC: rdData = {7'h00, pwrAcc_ff};
      `SPP_REG_DISTIME: rdData = {dis0v_ff, disTrans_ff};
      `SPP_REG_DISCTL: rdData = {7'h00, disEn_ff};
      `SPP_REG_ROLE: rdData = {5'h00, role_ff};
      `SPP_REG_MONDIS: rdData = {7'h00, rangeOff_ff};
      default: rdData = 8'h00;
    endcase
  end
  // Configuration registers
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      startup_ff <= `SPP_RST_STARTUP;
      ccSup_ff <= 8'h00;
      ilim_ff <= 8'h00;
      monCfg_ff <= 8'h00;
      vTarget_ff <= `SPP_RST_VTARGET;
      shiftHigh_ff <= `SPP_RST_SHIFT;
      shiftLow_ff <= `SPP_RST_SHIFT;
      pwrAcc_ff <= `SPP_RST_PWRACC;
      dis0v_ff <= `SPP_RST_DIS0V;
      disTrans_ff <= `SPP_RST_DISTRANS;
      disEn_ff <= `SPP_RST_DISEN;
      rangeOff_ff <= `SPP_RST_RANGEOFF;
      role_ff <= NVM_ROLE_DEFAULT;
      nvmPending_ff <= 1'b1;
    end else begin
      // The nonvolatile value is caught once, the cycle after reset release
      nvmPending_ff <= 1'b0;
      if (nvmPending_ff) begin
        role_ff <= nvmPowerRole;
      end
      // Falling back to the 5 V target on detach keeps a stale high target off the bus
      if (detachNow) begin
        vTarget_ff <= `SPP_RST_VTARGET;
      end
      if (wrStb_ff) begin
        case (wrAddr_ff)
          `SPP_REG_CONN: startup_ff <= wrData_ff[0];
          `SPP_REG_CCSUP: ccSup_ff <= wrData_ff;
          `SPP_REG_ILIM: ilim_ff <= wrData_ff;
          `SPP_REG_MONCFG: monCfg_ff <= wrData_ff;
          `SPP_REG_VTARGET: vTarget_ff <= wrData_ff[5:0];
          `SPP_REG_VSHIFT: begin
            shiftHigh_ff <= wrData_ff[7:4];
            shiftLow_ff <= wrData_ff[3:0];
          end
          `SPP_REG_PWRACC: pwrAcc_ff <= wrData_ff[0];
          `SPP_REG_DISTIME: begin
            dis0v_ff <= wrData_ff[7:4];
            disTrans_ff <= wrData_ff[3:0];
          end
          `SPP_REG_DISCTL: disEn_ff <= wrData_ff[0];
          `SPP_REG_ROLE: role_ff <= wrData_ff[2:0];
          `SPP_REG_MONDIS: rangeOff_ff <= wrData_ff[0];
          default: ;
        endcase
      end
    end
  end

  // Attach state machine
  always @* begin
    nxt_aState = aState_ff;
    nxt_orientLow = orientLow_ff;
    case (aState_ff)
      S_UNSNK, S_UNACC: begin
        if (rp1 ^ rp2) begin
          nxt_aState = S_ATT;
          nxt_orientLow = rp2;
        end else if (rp1 & rp2) begin
          nxt_aState = S_DBG;
          nxt_orientLow = (cc2RpLevel > cc1RpLevel);
        end else if (aState_ff == S_UNACC && ra1 && ra2) begin
          nxt_aState = S_AUDIO;
          nxt_orientLow = 1'b0;
        end else if (toggleTick_ff) begin
          nxt_aState = (aState_ff == S_UNSNK) ? S_UNACC : S_UNSNK;
        end
      end
      S_ATT: begin
        if (!(rp1 | rp2)) begin
          nxt_aState = S_UNSNK;
        end
      end
      S_DBG: begin
        if (!(rp1 & rp2)) begin
          nxt_aState = S_UNSNK;
        end
      end
      S_AUDIO: begin
        if (!(ra1 & ra2)) begin
          nxt_aState = S_UNSNK;
        end
      end
      default: begin
        nxt_aState = S_UNSNK;
      end
    endcase
    if (nxt_aState == S_UNSNK || nxt_aState == S_UNACC) begin
      nxt_orientLow = 1'b0;
    end
  end

  always @* begin
    case (aState_ff)
      S_ATT: connCode = `SPP_CONN_SINK;
      S_DBG: connCode = `SPP_CONN_DEBUG;
      S_AUDIO: connCode = `SPP_CONN_AUDIO;
      default: connCode = `SPP_CONN_NONE;
    endcase
  end
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      aState_ff <= S_UNSNK;
      orientLow_ff <= 1'b0;
      pathOn_ff <= 1'b0;
      toggleCnt_ff <= 32'h00000000;
      toggleTick_ff <= 1'b0;
    end else begin
      aState_ff <= nxt_aState;
      orientLow_ff <= nxt_orientLow;
      // Bus-voltage window check gates the sink path unless range checking is off
      pathOn_ff <= ((nxt_aState == S_ATT) || (nxt_aState == S_DBG)) && inRange;
      toggleTick_ff <= (toggleCnt_ff == TOGGLE_CYCLES - 1);
      if (toggleCnt_ff == TOGGLE_CYCLES - 1) begin
        toggleCnt_ff <= 32'h00000000;
      end else begin
        toggleCnt_ff <= toggleCnt_ff + 32'h00000001;
      end
    end
  end
  // Open-drain style pins: only ever pull low, enable low means driving
  assign sdaOut = 1'b0;
  assign sdaOeN = ~drive_ff;
  assign sinkPathEnableN = 1'b0;
  assign sinkPathOeN = ~pathOn_ff;
  assign orientOut = 1'b0;
  assign orientOeN = ~orientLow_ff;
  assign startupLowPower = startup_ff;
  assign cableSupplyOn = 1'b0;
  assign dischargePathOn = disEn_ff;
  assign dischargeToZeroTime = dis0v_ff;
  assign dischargeTransitionTime = disTrans_ff;
  assign poweredAccessoryDetectOn = pwrAcc_ff;

endmodule // spp_sink_attach_ctrl

`default_nettype wire

/* File: test/spp_sink_attach_props.sv */
// Checker for the sink attach controller, watching only its top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module spp_sink_attach_props (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Terminations
  input wire [1:0] cc1Term,
  input wire [1:0] cc2Term,
  // Pins and fields
  input wire sinkPathOeN,
  input wire orientOeN,
  input wire sdaOut,
  input wire sinkPathEnableN,
  input wire orientOut,
  input wire startupLowPower,
  input wire cableSupplyOn,
  input wire dischargePathOn,
  input wire [3:0] dischargeToZeroTime,
  input wire [3:0] dischargeTransitionTime,
  input wire poweredAccessoryDetectOn
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  reset_fields_a: assert property ($rose(rst_b) |-> !startupLowPower && dischargePathOn
    && poweredAccessoryDetectOn) else $error("field reset value wrong");
  reset_times_a: assert property ($rose(rst_b) |-> dischargeToZeroTime == 4'hA
    && dischargeTransitionTime == 4'hA) else $error("discharge time reset wrong");
  path_source_a: assert property (!sinkPathOeN |->
    $past(cc1Term == 2'h3 || cc2Term == 2'h3)) else $error("path on without source");
  path_release_a: assert property (cc1Term != 2'h3 && cc2Term != 2'h3 |=> sinkPathOeN)
    else $error("path not released");
  orient_release_a: assert property (cc2Term != 2'h3 |=> orientOeN)
    else $error("orientation driven without source on line two");
  orient_low_a: assert property ((cc1Term != 2'h3 && cc2Term == 2'h3) [*2] |=> !orientOeN)
    else $error("orientation not driven");
  pin_levels_a: assert property (!sdaOut && !sinkPathEnableN && !orientOut)
    else $error("pin value not low");
  supply_off_a: assert property (!cableSupplyOn)
    else $error("cable supply on");
endmodule // spp_sink_attach_props
bind spp_sink_attach_ctrl spp_sink_attach_props i_spp_sink_attach_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .cc1Term(cc1Term), .cc2Term(cc2Term),
  .sinkPathOeN(sinkPathOeN), .orientOeN(orientOeN), .sdaOut(sdaOut),
  .sinkPathEnableN(sinkPathEnableN), .orientOut(orientOut),
  .startupLowPower(startupLowPower), .cableSupplyOn(cableSupplyOn),
  .dischargePathOn(dischargePathOn), .dischargeToZeroTime(dischargeToZeroTime),
  .dischargeTransitionTime(dischargeTransitionTime),
  .poweredAccessoryDetectOn(poweredAccessoryDetectOn));
`default_nettype wire

/* File: test/spp_far_end.sv */
// Far-end party on the two lines: source, cable or accessory terminations.
// Assumes the bench picks the party by mode; a source drives the bus level.
`timescale 1ns/100ps
`default_nettype none
module spp_far_end (
  // Selection
  input wire logic [3:0] mode,
  input wire logic [5:0] busLevel,
  // Terminations and bus sense
  output logic [1:0] cc1Term,
  output logic [1:0] cc2Term,
  output logic [1:0] cc1RpLevel,
  output logic [1:0] cc2RpLevel,
  output logic [5:0] busVoltageSenseIn
);
  always_comb begin
    case (mode)
      4'h1: {cc1Term, cc2Term} = 4'hC;
      4'h2: {cc1Term, cc2Term} = 4'h3;
      4'h3: {cc1Term, cc2Term} = 4'hD;
      4'h4, 4'h5: {cc1Term, cc2Term} = 4'hF;
      4'h6: {cc1Term, cc2Term} = 4'h5;
      4'h7: {cc1Term, cc2Term} = 4'hA;
      4'h8: {cc1Term, cc2Term} = 4'h9;
      4'h9: {cc1Term, cc2Term} = 4'h4;
      default: {cc1Term, cc2Term} = 4'h0;
    endcase
    // Mode 4 has the higher level on line two, mode 5 on line one
    {cc1RpLevel, cc2RpLevel} = (mode == 4'h4) ? 4'h1 : 4'h9;
    // No source, no bus voltage
    busVoltageSenseIn = (cc1Term == 2'h3 || cc2Term == 2'h3) ? busLevel : 6'h00;
  end
endmodule // spp_far_end
`default_nettype wire

/* File: test/spp_sink_attach_ctrl_tb_top.sv */
// Testbench for the sink attach controller: serial register tasks and port checks.
// Assumes the far-end model drives terminations and the bus sense code.
`timescale 1ns/100ps
`default_nettype none
`include "spp_consts.vh"
module spp_sink_attach_ctrl_tb_top;
  localparam logic [6:0] ADDR = `SPP_DEV_ADDR;
  logic clk_sys, rst_b, sclDrv, sdaDrv;
  logic [3:0] mode;
  logic [2:0] nvmRole;
  logic [5:0] busLevel, busVoltageSenseIn;
  logic [1:0] cc1Term, cc2Term, cc1RpLevel, cc2RpLevel;
  wire sdaOut, sdaOeN, sinkPathEnableN, sinkPathOeN, orientOut, orientOeN;
  wire startupLowPower, cableSupplyOn, dischargePathOn, poweredAccessoryDetectOn;
  wire [3:0] dischargeToZeroTime, dischargeTransitionTime;
  wire sdaLine;
  int num_errors, n_tests;
  logic [7:0] repExp [10] = '{`SPP_CONN_NONE, `SPP_CONN_SINK, `SPP_CONN_SINK, `SPP_CONN_SINK,
    `SPP_CONN_DEBUG, `SPP_CONN_DEBUG, `SPP_CONN_AUDIO, 8'h00, 8'h00, 8'h00};
  logic [7:0] stExp [10] = '{8'hFF, 8'h02, 8'h02, 8'h02, 8'h03, 8'h03, 8'h04, 8'hFF, 8'hFF, 8'hFF};
  logic [1:0] pinExp [10] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3};
  logic [7:0] rngShift [7] = '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'h00, 8'h00};
  logic [5:0] rngBus [7] = '{6'h3C, 6'h3D, 6'h28, 6'h27, 6'h27, 6'h33, 6'h32};
  logic [6:0] rngOff = 7'h10;
  logic [6:0] rngPath = 7'h2A;
  // Open-drain line with a pull-up
  assign sdaLine = sdaDrv & sdaOeN;
  spp_sink_attach_ctrl #(.TOGGLE_CYCLES(8)) i_spp_sink_attach_ctrl (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclIn(sclDrv), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .nvmPowerRole(nvmRole), .cc1Term(cc1Term), .cc2Term(cc2Term),
    .cc1RpLevel(cc1RpLevel), .cc2RpLevel(cc2RpLevel), .busVoltageSenseIn(busVoltageSenseIn),
    .sinkPathEnableN(sinkPathEnableN), .sinkPathOeN(sinkPathOeN), .orientOut(orientOut),
    .orientOeN(orientOeN), .startupLowPower(startupLowPower), .cableSupplyOn(cableSupplyOn),
    .dischargePathOn(dischargePathOn), .dischargeToZeroTime(dischargeToZeroTime),
    .dischargeTransitionTime(dischargeTransitionTime),
    .poweredAccessoryDetectOn(poweredAccessoryDetectOn));
  spp_far_end i_spp_far_end (.mode(mode), .busLevel(busLevel), .cc1Term(cc1Term),
    .cc2Term(cc2Term), .cc1RpLevel(cc1RpLevel), .cc2RpLevel(cc2RpLevel),
    .busVoltageSenseIn(busVoltageSenseIn));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bit sampled mid-way through the clock-high phase, where the device output stands
  task automatic sbit(input logic b, output logic r);
    sdaDrv <= b;
    tick(2);
    sclDrv <= 1'b1;
    tick(2);
    #1 r = sdaLine;
    tick(2);
    sclDrv <= 1'b0;
    tick(2);
  endtask
  task automatic start();
    sdaDrv <= 1'b1;
    sclDrv <= 1'b1;
    tick(4);
    sdaDrv <= 1'b0;
    tick(4);
    sclDrv <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sdaDrv <= 1'b0;
    tick(2);
    sclDrv <= 1'b1;
    tick(4);
    sdaDrv <= 1'b1;
    tick(4);
  endtask
  task automatic wbyte(input logic [7:0] b, input logic ackExp);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(b[i], r);
    sbit(1'b1, r);
    chk({7'h0, r}, {7'h0, ackExp});
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    start();
    wbyte({ADDR, 1'b0}, 1'b0);
    wbyte(off, 1'b0);
    wbyte(d, 1'b0);
    stop();
  endtask
  // Pointer set by a write, then one byte read and ended by a not-acknowledge
  task automatic rdChk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] d;
    logic r;
    start();
    wbyte({ADDR, 1'b0}, 1'b0);
    wbyte(off, 1'b0);
    stop();
    start();
    wbyte({ADDR, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--) sbit(1'b1, d[i]);
    sbit(1'b1, r);
    stop();
    chk(d, exp);
  endtask
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A full run is about 14k cycles
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
    mode = 4'h0;
    busLevel = 6'h32;
    nvmRole = 3'h1;
    num_errors = 0;
    n_tests = 0;
    tick(20);
    rst_b <= 1'b1;
    tick(4);
    chk({7'h0, startupLowPower}, 8'h00);
    chk({7'h0, poweredAccessoryDetectOn}, 8'h01);
    chk({dischargeToZeroTime, dischargeTransitionTime}, 8'hAA);
    rdChk(8'h21, 8'h32);
    rdChk(8'h22, 8'hAA);
    rdChk(8'h24, 8'h01);
    rdChk(8'h26, 8'h01);
    rdChk(8'h28, 8'h01);
    rdChk(8'h2E, 8'h00);
    wr(8'h30, 8'h5A);
    rdChk(8'h30, 8'h00);
    wr(8'h28, 8'h05);
    rdChk(8'h28, 8'h05);
    wr(8'h28, 8'h01);
    wr(8'h0E, 8'h01);
    tick(2);
    chk({7'h0, startupLowPower}, 8'h01);
    wr(8'h0E, 8'h00);
    // Foreign address is left unanswered
    start();
    wbyte({ADDR ^ 7'h01, 1'b0}, 1'b1);
    stop();
    // Every far-end party, entered from the open state
    for (int m = 0; m < 10; m++) begin
      mode <= 4'h0;
      tick(40);
      mode <= m[3:0];
      tick(40);
      chk({6'h0, sinkPathOeN, orientOeN}, {6'h0, pinExp[m]});
      rdChk(8'h0E, repExp[m]);
      if (stExp[m] !== 8'hFF) rdChk(8'h11, stExp[m]);
    end
    // Window edges, with and without range checking
    mode <= 4'h1;
    for (int k = 0; k < 7; k++) begin
      wr(8'h22, rngShift[k]);
      wr(8'h2E, {7'h0, rngOff[k]});
      busLevel <= rngBus[k];
      tick(4);
      chk({7'h0, sinkPathOeN}, {7'h0, rngPath[k]});
    end
    // Mid-run reset: a new nonvolatile role is caught, the window fields return to reset
    nvmRole <= 3'h6;
    rst_b <= 1'b0;
    tick(2);
    rst_b <= 1'b1;
    tick(4);
    chk({7'h0, sinkPathOeN}, 8'h00);
    rdChk(8'h28, 8'h06);
    rdChk(8'h22, 8'hAA);
    conclude();
  end
endmodule // spp_sink_attach_ctrl_tb_top
`default_nettype wire
